// *** pbc_pkg.sv ***
// constants for the power budget capability register bank
package pbc_pkg;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned DATA_W = 32;
   // register offsets
   localparam logic [11:0] OFS_CAP_HEADER = 12'h20C;
   localparam logic [11:0] OFS_ENTRY_SELECT = 12'h210;
   localparam logic [11:0] OFS_ENTRY_DATA = 12'h214;
   localparam logic [11:0] OFS_SYS_ALLOC = 12'h218;
   // header fields
   localparam logic [15:0] CAP_ID = 16'h0004;
   localparam logic [3:0] CAP_VERSION = 4'h1;
   localparam logic [11:0] NEXT_PTR_UP = 12'h230;
   localparam logic [11:0] NEXT_PTR_DOWN = 12'h220;
   localparam int unsigned HDR_ID_LSB = 0;
   localparam int unsigned HDR_VER_LSB = 16;
   localparam int unsigned HDR_NEXT_LSB = 20;
   // select field
   localparam int unsigned SEL_W = 8;
   localparam logic [7:0] SEL_RESET = 8'h00;
   localparam logic [7:0] SEL_D0_MAX = 8'h00;
   localparam logic [7:0] SEL_D0_SUST = 8'h01;
   // data register fields
   localparam int unsigned BASE_LSB = 0;
   localparam int unsigned SCALE_LSB = 8;
   localparam int unsigned SUBST_LSB = 10;
   localparam int unsigned PMST_LSB = 13;
   localparam int unsigned TYPE_LSB = 15;
   localparam int unsigned RAIL_LSB = 18;
   localparam logic [7:0] BASE_RESET = 8'h04;
   localparam logic [1:0] SCALE_RESET = 2'h0;
   localparam logic [2:0] SUBST_RESET = 3'h0;
   localparam logic [1:0] PMST_D0 = 2'h0;
   localparam logic [2:0] TYPE_MAX = 3'h7;
   localparam logic [2:0] TYPE_SUST = 3'h1;
   localparam logic [2:0] RAIL_RESET = 3'h2;
   // system allocation
   localparam int unsigned SYS_ALLOC_BIT = 0;
   localparam logic SYS_ALLOC_RESET = 1'b0;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage : pbc_pkg

// *** pbc_regs.sv ***
// power budget capability registers of one switch port
// Overview of operation
// - header bits 15:0 read capability id 0004h
// - header bits 19:16 read version one
// - next pointer 230h upstream, 220h downstream
// - eight-bit writable select index, resets zero
// - index 00h max, 01h sustained budget
// - other indexes report zero power budget
// - base power bits 7:0, reset 04h, loadable
// - scale bits 9:8 read-only, reset zero
// - sub-state bits 12:10 read-only, zero
// - pm state bits 14:13 read D0
// - type bits 17:15 default all ones
// - power rail bits 20:18 reset 010b
// - system allocated bit 0, loadable, reset zero
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
module pbc_regs (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // port strap
   input wire logic port_is_upstream,
   // configuration loader
   input wire logic load_valid,
   input wire logic [7:0] load_base_power,
   input wire logic load_sys_alloc,
   // register port
   input wire logic [pbc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [pbc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [pbc_pkg::DATA_W-1:0] reg_rdata
);
   import pbc_pkg::*;

   logic port_up_q;
   logic [SEL_W-1:0] sel_q;
   logic [SEL_W-1:0] sel_d;
   logic [7:0] base_q;
   logic [7:0] base_d;
   logic sys_alloc_q;
   logic sys_alloc_d;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;

   // address decode
   wire hit_hdr = reg_addr == OFS_CAP_HEADER;
   wire hit_sel = reg_addr == OFS_ENTRY_SELECT;
   wire hit_data = reg_addr == OFS_ENTRY_DATA;
   wire hit_alloc = reg_addr == OFS_SYS_ALLOC;

   // header word
   wire [11:0] next_ptr = port_up_q ? NEXT_PTR_UP : NEXT_PTR_DOWN;
   wire [31:0] hdr_word = {next_ptr, CAP_VERSION, CAP_ID};

   // select word, upper bits zero
   wire [31:0] sel_word = {24'h000000, sel_q};

   // data word per selected condition
   wire sel_max = sel_q == SEL_D0_MAX;
   wire sel_sust = sel_q == SEL_D0_SUST;
   wire sel_ok = sel_max | sel_sust;
   wire [2:0] type_fld = sel_sust ? TYPE_SUST : TYPE_MAX;
   wire [20:0] entry_fld = {RAIL_RESET, type_fld, PMST_D0, SUBST_RESET, SCALE_RESET, base_q};
   wire [31:0] data_word = sel_ok ? {11'h000, entry_fld} : READ_ZERO;

   // system allocation word
   wire [31:0] alloc_word = {31'h00000000, sys_alloc_q};

   // read mux, unmapped reads zero
   wire [31:0] rd_mux = hit_hdr ? hdr_word :
                        hit_sel ? sel_word :
                        hit_data ? data_word :
                        hit_alloc ? alloc_word : READ_ZERO;

   // next-state values
   assign sel_d = (reg_wr && hit_sel) ? reg_wdata[SEL_W-1:0] : sel_q;
   assign base_d = load_valid ? load_base_power : base_q;
   assign sys_alloc_d = load_valid ? load_sys_alloc : sys_alloc_q;
   assign rdata_d = reg_rd ? rd_mux : READ_ZERO;
   assign reg_rdata = rdata_q;

   // strap follower
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         port_up_q <= 1'b0;
      end else begin
         port_up_q <= port_is_upstream;
      end
   end

   // writable and loadable fields
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sel_q <= SEL_RESET;
         base_q <= BASE_RESET;
         sys_alloc_q <= SYS_ALLOC_RESET;
      end else begin
         sel_q <= sel_d;
         base_q <= base_d;
         sys_alloc_q <= sys_alloc_d;
      end
   end

   // read data, valid one cycle after strobe
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= READ_ZERO;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // header reads
   a_hdr_cap_id: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && hit_hdr |=> reg_rdata[15:0] == 16'h0004)
      else $error("header id wrong");

   a_hdr_version: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && hit_hdr |=> reg_rdata[19:16] == 4'h1)
      else $error("header version wrong");

   a_hdr_next_ptr: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && hit_hdr |=>
         reg_rdata[31:20] == ($past(port_up_q) ? 12'h230 : 12'h220))
      else $error("next pointer wrong for port type");

   // select register
   a_sel_write_back: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_wr && hit_sel ##1 reg_rd && hit_sel |=>
         reg_rdata == {24'h000000, $past(reg_wdata[7:0], 2)})
      else $error("select index not read back");

   a_sel_hold: assert property (
      @(posedge clk) disable iff (!reset_n)
      !(reg_wr && hit_sel) |=> $stable(sel_q))
      else $error("select index changed without write");

   // data register
   a_data_max: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && hit_data && sel_q == 8'h00 |=>
         reg_rdata[17:15] == 3'b111 && reg_rdata[7:0] == $past(base_q))
      else $error("D0 max entry wrong");

   a_data_sust: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && hit_data && sel_q == 8'h01 |=>
         reg_rdata[17:15] == 3'b001 && reg_rdata[7:0] == $past(base_q))
      else $error("D0 sustained entry wrong");

   a_data_unsup: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && hit_data && sel_q > 8'h01 |=> reg_rdata == 32'h0000_0000)
      else $error("unsupported index not zero");

   a_data_fixed: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && hit_data && sel_q < 8'h02 |=>
         reg_rdata[14:8] == 7'h00 && reg_rdata[20:18] == 3'b010)
      else $error("fixed data fields wrong");

   a_base_reset: assert property (
      @(posedge clk)
      !reset_n |=> base_q == 8'h04 || $past(load_valid))
      else $error("base power reset value wrong");

   a_base_load: assert property (
      @(posedge clk) disable iff (!reset_n)
      load_valid ##1 (reg_rd && hit_data && sel_q == 8'h00) |=>
         reg_rdata[7:0] == $past(load_base_power, 2))
      else $error("loaded base power not reported");

   // system allocation
   a_alloc_read: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && hit_alloc |=> reg_rdata == {31'h00000000, $past(sys_alloc_q)})
      else $error("system allocated read wrong");

   // read-only writes and idle read data
   a_ro_ignored: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_wr && !load_valid && (hit_data || hit_alloc || hit_hdr) |=>
         $stable(base_q) && $stable(sys_alloc_q) && $stable(sel_q))
      else $error("write changed read-only field");

   a_rd_only_one: assert property (
      @(posedge clk) disable iff (!reset_n)
      !reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("read data outside answer cycle");

   // reset values
   a_rdata_reset: assert property (
      @(posedge clk)
      !reset_n |-> reg_rdata == 32'h0000_0000)
      else $error("read data not zero in reset");

   a_sel_reset: assert property (
      @(posedge clk)
      !reset_n |-> sel_q == 8'h00)
      else $error("select index not zero in reset");

   a_alloc_reset: assert property (
      @(posedge clk)
      !reset_n |-> sys_alloc_q == 1'b0)
      else $error("system allocated not zero in reset");

   a_strap_reset: assert property (
      @(posedge clk)
      !reset_n |-> port_up_q == 1'b0)
      else $error("strap flop not downstream in reset");

   a_rd_after_reset: assert property (
      @(posedge clk) disable iff (!reset_n)
      $rose(reset_n) |-> reg_rdata == 32'h0000_0000)
      else $error("read data not zero after reset");

   // header details
   a_hdr_upstream: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && hit_hdr && port_up_q |=> reg_rdata[31:20] == 12'h230)
      else $error("upstream next pointer wrong");

   a_hdr_downstream: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && hit_hdr && !port_up_q |=> reg_rdata[31:20] == 12'h220)
      else $error("downstream next pointer wrong");

   a_strap_follow: assert property (
      @(posedge clk) disable iff (!reset_n)
      1'b1 |=> port_up_q == $past(port_is_upstream))
      else $error("strap flop not following pin");

   a_hdr_low_word: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && hit_hdr |=> reg_rdata[19:0] == 20'h1_0004)
      else $error("header id and version wrong");

   // select details
   a_sel_reserved: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && hit_sel |=> reg_rdata[31:8] == 24'h000000)
      else $error("select reserved bits not zero");

   a_sel_read: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && hit_sel |=> reg_rdata[7:0] == $past(sel_q))
      else $error("select read value wrong");

   a_sel_write: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_wr && hit_sel |=> sel_q == $past(reg_wdata[7:0]))
      else $error("select write not taken");

   a_sel_other_wr: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_wr && !hit_sel |=> $stable(sel_q))
      else $error("select changed by other write");

   // data details
   a_data_reserved: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && hit_data |=> reg_rdata[31:21] == 11'h000)
      else $error("data reserved bits not zero");

   a_data_scale: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && hit_data && sel_q < 8'h02 |=> reg_rdata[9:8] == 2'b00)
      else $error("data scale wrong");

   a_data_substate: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && hit_data && sel_q < 8'h02 |=> reg_rdata[12:10] == 3'b000)
      else $error("data sub-state wrong");

   a_data_pmstate: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && hit_data && sel_q < 8'h02 |=> reg_rdata[14:13] == 2'b00)
      else $error("data pm state wrong");

   a_data_rail: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && hit_data && sel_q < 8'h02 |=> reg_rdata[20:18] == 3'b010)
      else $error("data power rail wrong");

   a_data_type_max: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && hit_data && sel_q == 8'h00 |=> reg_rdata[17:15] == 3'b111)
      else $error("data type not maximum");

   a_sust_fields: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && hit_data && sel_q == 8'h01 |=>
         reg_rdata[20:18] == 3'b010 && reg_rdata[14:8] == 7'h00)
      else $error("sustained entry fields wrong");

   a_data_unsup_hi: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && hit_data && sel_q[7:1] != 7'h00 |=> reg_rdata == 32'h0000_0000)
      else $error("high index entry not zero");

   a_data_ro_write: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_wr && hit_data && !load_valid |=> $stable(base_q))
      else $error("data write changed base power");

   // loader and system allocation
   a_alloc_reserved: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && hit_alloc |=> reg_rdata[31:1] == 31'h00000000)
      else $error("allocation reserved bits not zero");

   a_alloc_load: assert property (
      @(posedge clk) disable iff (!reset_n)
      load_valid |=> sys_alloc_q == $past(load_sys_alloc))
      else $error("system allocated not loaded");

   a_base_load_q: assert property (
      @(posedge clk) disable iff (!reset_n)
      load_valid |=> base_q == $past(load_base_power))
      else $error("base power not loaded");

   a_base_hold: assert property (
      @(posedge clk) disable iff (!reset_n)
      !load_valid |=> $stable(base_q))
      else $error("base power changed without load");

   a_alloc_hold: assert property (
      @(posedge clk) disable iff (!reset_n)
      !load_valid |=> $stable(sys_alloc_q))
      else $error("system allocated changed without load");

   // unmapped and idle reads
   a_unmapped_zero: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_rd && !(hit_hdr || hit_sel || hit_data || hit_alloc) |=> reg_rdata == 32'h0)
      else $error("unmapped read not zero");

   a_wr_no_rdata: assert property (
      @(posedge clk) disable iff (!reset_n)
      reg_wr && !reg_rd |=> reg_rdata == 32'h0000_0000)
      else $error("write produced read data");

endmodule : pbc_regs

// *** tb.sv ***
// self-checking bench for the power budget capability registers
`timescale 1ns/1ns
module tb;
   import pbc_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic port_is_upstream = 1'b0;
   logic load_valid = 1'b0;
   logic [7:0] load_base_power = 8'h00;
   logic load_sys_alloc = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   int n_mismatch = 0;
   int n_compared = 0;
   int cycles = 0;
   logic [7:0] bad_sel [3] = '{8'h02, 8'h80, 8'hFF};
   always #50 clk = ~clk;
   pbc_regs DUT (.clk(clk), .reset_n(reset_n), .port_is_upstream(port_is_upstream),
      .load_valid(load_valid), .load_base_power(load_base_power),
      .load_sys_alloc(load_sys_alloc), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   // read strobe for one cycle, data sampled in the following cycle
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask : rd_chk
   task automatic conclude;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         n_mismatch++;
         conclude();
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      reset_n <= 1'b1;
      rd_chk(OFS_ENTRY_SELECT, 32'h0000_0000);
      rd_chk(OFS_CAP_HEADER, 32'h2201_0004);
      rd_chk(OFS_ENTRY_DATA, 32'h000B_8004);
      // read data drops back to zero
      @(posedge clk);
      #1 chk(reg_rdata, 32'h0000_0000);
      rd_chk(OFS_SYS_ALLOC, 32'h0000_0000);
      // upper select bits dropped, sustained entry
      wr(OFS_ENTRY_SELECT, 32'hFFFF_FF01);
      rd_chk(OFS_ENTRY_SELECT, 32'h0000_0001);
      rd_chk(OFS_ENTRY_DATA, 32'h0008_8004);
      foreach (bad_sel[i]) begin
         wr(OFS_ENTRY_SELECT, {24'h000000, bad_sel[i]});
         rd_chk(OFS_ENTRY_DATA, 32'h0000_0000);
      end
      // write then read with no gap
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= OFS_ENTRY_SELECT;
      reg_wdata <= 32'h0000_0055;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, 32'h0000_0055);
      // index back to 00h, then writes to read-only and unmapped places
      wr(OFS_ENTRY_SELECT, 32'h0000_0000);
      wr(OFS_CAP_HEADER, 32'hFFFF_FFFF);
      wr(OFS_ENTRY_DATA, 32'hFFFF_FFFF);
      wr(OFS_SYS_ALLOC, 32'hFFFF_FFFF);
      wr(12'h21C, 32'hFFFF_FFFF);
      rd_chk(OFS_CAP_HEADER, 32'h2201_0004);
      rd_chk(OFS_ENTRY_DATA, 32'h000B_8004);
      rd_chk(OFS_SYS_ALLOC, 32'h0000_0000);
      rd_chk(12'h21C, 32'h0000_0000);
      // upstream strap
      @(posedge clk);
      port_is_upstream <= 1'b1;
      rd_chk(OFS_CAP_HEADER, 32'h2301_0004);
      // loader replaces defaults
      @(posedge clk);
      load_valid <= 1'b1;
      load_base_power <= 8'hFF;
      load_sys_alloc <= 1'b1;
      @(posedge clk);
      load_valid <= 1'b0;
      reg_rd <= 1'b1;
      reg_addr <= OFS_ENTRY_DATA;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, 32'h000B_80FF);
      rd_chk(OFS_SYS_ALLOC, 32'h0000_0001);
      wr(OFS_ENTRY_SELECT, 32'h0000_0001);
      rd_chk(OFS_ENTRY_DATA, 32'h0008_80FF);
      conclude();
   end
endmodule : tb
